// ==== hw/pts_pkg.sv ====
// shared constants for the precision-time timestamp path
package pts_pkg;
  // data widths
  localparam int BYTE_W = 8;
  localparam int TIME_W = 80;
  localparam int CMD_W = 64;
  localparam int USER_W = 128;
  localparam int STAMP_W = 128;
  localparam int OFF_W = 16;
  localparam int TAG_W = 16;
  // transmit user sideband layout
  localparam int USER_UNDERRUN = 0;
  localparam int USER_CMD_LO = 64;
  // command field layout
  localparam int CMD_OP_LO = 0;
  localparam int CMD_CHK_UPD = 8;
  localparam int CMD_TAG_LO = 16;
  localparam int CMD_TS_OFF_LO = 32;
  localparam int CMD_CHK_OFF_LO = 48;
  localparam logic [1:0] OP_ONE_STEP = 2'h1;
  localparam logic [1:0] OP_TWO_STEP = 2'h2;
  // time-of-day layout: seconds above nanoseconds
  localparam int NS_W = 32;
  localparam int SEC_W = 48;
  localparam logic [31:0] NS_PER_SEC = 32'h3b9aca00;
  // correction format counts nanoseconds scaled by 2^16
  localparam int CORR_FRAC_W = 16;
  // latency defaults, in nanoseconds
  localparam logic [31:0] TX_LAT_DEFAULT_NS = 32'h00000040;
  localparam logic [31:0] RX_LAT_DEFAULT_NS = 32'h00000030;
  // inserted stamp lengths, in bytes
  localparam logic [OFF_W-1:0] DAY_STAMP_BYTES = 16'h000a;
  localparam logic [OFF_W-1:0] CORR_STAMP_BYTES = 16'h0008;
  localparam logic [OFF_W-1:0] CORR_SKIP_BYTES = 16'h0002;
  // udp checksum sits this many bytes before the correction field
  localparam logic [OFF_W-1:0] CORR_CHK_GAP = 16'h000a;
  // in-line receive stamp occupies the preamble slot
  localparam int INL_BYTES = 8;
  localparam logic [3:0] INL_COUNT = 4'h8;
  // frame check sequence
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [1:0] FCS_LAST = 2'h3;
  // transmit fifo word: {last, underrun, command, data}
  localparam int TXF_DEPTH = 16;
  localparam int TXF_W = BYTE_W + CMD_W + 2;
  localparam int TXF_UNDERRUN = BYTE_W + CMD_W;
  localparam int TXF_LAST = BYTE_W + CMD_W + 1;
  // transmit sequencer
  typedef enum logic [0:0] {
    TX_DATA = 1'b0,
    TX_FCS = 1'b1
  } pts_tx_state_t;
endpackage

// ==== hw/pts_fifo.sv ====
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pts_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  // storage array
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtrQ;
  logic [AW-1:0] rdPtrQ;
  logic [AW:0] cntQ;
  logic [AW:0] cntD;
  logic notFullQ;
  logic push;
  logic pop;

  assign push = inValid && notFullQ;
  assign pop = outReady && (cntQ != '0);
  assign inReady = notFullQ;
  assign outValid = (cntQ != '0);
  assign outData = mem[rdPtrQ];

  // occupancy after this cycle
  always_comb
  begin
    cntD = cntQ;
    if (push && !pop)
      cntD = cntQ + 1'b1;
    else if (pop && !push)
      cntD = cntQ - 1'b1;
  end

  // pointers, count and registered space flag
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      cntQ <= '0;
      notFullQ <= 1'b1;
    end
    else
    begin
      if (push)
        wrPtrQ <= wrPtrQ + 1'b1;
      if (pop)
        rdPtrQ <= rdPtrQ + 1'b1;
      cntQ <= cntD;
      notFullQ <= (cntD != DEPTH[AW:0]);
    end
  end

  // write port
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtrQ] <= inData;
  end
endmodule
`default_nettype wire

// ==== hw/pts_timestamp_path.sv ====
// timestamp capture, adjust, insert and delivery for transmit and receive
//
// Summary of operation
// [R1] capture transmit time at frame start delimiter
// [R2] one-step stamp updates udp checksum and fcs
// [R3] add configurable transmit latency, default full path
// [R4] latency adjust applies to both formats
// [R5] stamp every receive frame, 80-bit out-of-band
// [R6] in-line stamp: low seconds then nanoseconds
// [R7] correction format: 64-bit stamp out-of-band too
// [R8] capture receive time at phy delimiter
// [R9] subtract configurable receive latency, default phy path
// [R10] partner supplies correction value, standard encoding
// [R11] stamp stream valid with first frame word
// [R12] stamp stream runs on receive clock
// [R13] stamp word: ns low, seconds above, rest zero
// [R14] in-line option puts stamp before frame
// [R15] in-line off leaves receive stream unchanged
// [R16] client gives command on widened sideband
// [R17] command held valid with first word
// [R18] sideband bit zero signals underrun
// [R19] sideband bits 63 to 1 ignored
// [R20] command bits used only without in-line command
// [R21] op bits: one-step, two-step, else no-op
// [R22] tag returned with transmit stamp
// [R23] offset locates inserted stamp from frame start
// [R24] stamp stream valid one cycle per frame
`timescale 1ns/1ps
`default_nettype none
module pts_timestamp_path (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [pts_pkg::TIME_W-1:0] timeNow,
  input wire logic [pts_pkg::CMD_W-1:0] corrNow,
  input wire logic useCorrFormat,
  input wire logic inlineCmdEnable,
  input wire logic inlineRxEnable,
  input wire logic [31:0] txLatencyNs,
  input wire logic txLatencyLoad,
  input wire logic [31:0] rxLatencyNs,
  input wire logic rxLatencyLoad,
  input wire logic [pts_pkg::BYTE_W-1:0] txInData,
  input wire logic txInValid,
  input wire logic txInLast,
  input wire logic [pts_pkg::USER_W-1:0] txInUser,
  output logic txInReady,
  output logic [pts_pkg::BYTE_W-1:0] txOutData,
  output logic txOutValid,
  output logic txOutLast,
  output logic txOutUnderrun,
  input wire logic txOutReady,
  output logic [pts_pkg::TIME_W-1:0] txStampTime,
  output logic [pts_pkg::TAG_W-1:0] txStampTag,
  output logic txStampValid,
  input wire logic phySfd,
  input wire logic [pts_pkg::BYTE_W-1:0] rxInData,
  input wire logic rxInValid,
  input wire logic rxInLast,
  output logic [pts_pkg::BYTE_W-1:0] rxOutData,
  output logic rxOutValid,
  output logic rxOutLast,
  output logic [pts_pkg::STAMP_W-1:0] rxStampStreamData,
  output logic rxStampStreamValid
);
  import pts_pkg::*;

  // time-of-day plus or minus a latency, with seconds carry/borrow
  function automatic logic [TIME_W-1:0] dayTimeAdjust(input logic [TIME_W-1:0] t,
    input logic [31:0] lat, input logic sub);
    logic [SEC_W-1:0] s;
    logic [NS_W:0] n;
    s = t[TIME_W-1:NS_W];
    n = {1'b0, t[NS_W-1:0]};
    if (!sub)
    begin
      n = n + {1'b0, lat};
      if (n >= {1'b0, NS_PER_SEC})
      begin
        n = n - {1'b0, NS_PER_SEC};
        s = s + 1'b1;
      end
    end
    else if (t[NS_W-1:0] >= lat)
      n = n - {1'b0, lat};
    else
    begin
      n = n + {1'b0, NS_PER_SEC} - {1'b0, lat};
      s = s - 1'b1;
    end
    return {s, n[NS_W-1:0]};
  endfunction

  // adjusted stamp in the selected format, correction value zero-extended
  function automatic logic [TIME_W-1:0] stampOf(input logic corr,
    input logic [TIME_W-1:0] t, input logic [CMD_W-1:0] c,
    input logic [31:0] lat, input logic sub);
    logic [CMD_W-1:0] l;
    l = {16'h0000, lat, 16'h0000};
    if (corr)
      return {16'h0000, (sub ? c - l : c + l)};
    return dayTimeAdjust(t, lat, sub);
  endfunction

  // byte idx of an 80-bit value, most significant first
  function automatic logic [BYTE_W-1:0] pickByte(input logic [TIME_W-1:0] v,
    input logic [3:0] idx);
    return v[(TIME_W-1) - 8*idx -: BYTE_W];
  endfunction

  // one reflected crc32 byte step
  function automatic logic [31:0] crcByte(input logic [31:0] c,
    input logic [BYTE_W-1:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < BYTE_W; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction

  // latency registers, loaded by software, reset to path defaults
  logic [31:0] txLatQ;
  logic [31:0] rxLatQ;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      txLatQ <= TX_LAT_DEFAULT_NS; // [R3]
      rxLatQ <= RX_LAT_DEFAULT_NS; // [R9]
    end
    else
    begin
      if (txLatencyLoad)
        txLatQ <= txLatencyNs;
      if (rxLatencyLoad)
        rxLatQ <= rxLatencyNs;
    end
  end

  // ---------------- transmit ----------------
  logic [TXF_W-1:0] fWord; // fifo head word
  logic fValid;
  logic fPop;
  logic [CMD_W-1:0] cmdIn; // command written into the fifo
  pts_tx_state_t txStateQ;
  logic txSofQ; // next popped byte opens a frame
  logic [OFF_W-1:0] txPosQ; // byte position from destination address
  logic [CMD_W-1:0] txCmdQ;
  logic [TIME_W-1:0] txTimeQ;
  logic [31:0] crcQ;
  logic [1:0] fcsCntQ;
  logic txAdv;
  logic popNow;
  logic [CMD_W-1:0] cmdNow;
  logic [TIME_W-1:0] stampTx;
  logic [TIME_W-1:0] tsNow;
  logic [1:0] op;
  logic oneStep;
  logic [OFF_W-1:0] tsOff;
  logic [OFF_W-1:0] chkOff;
  logic [OFF_W-1:0] rel;
  logic [OFF_W-1:0] tsIdx;
  logic inTs;
  logic inChk;
  logic [BYTE_W-1:0] outByte;

  // command only taken from the sideband without in-line command mode
  assign cmdIn = inlineCmdEnable ? '0 : txInUser[USER_W-1:USER_CMD_LO]; // [R20] [R16]

  pts_fifo #(
    .WIDTH(TXF_W),
    .DEPTH(TXF_DEPTH)
  ) u_txFifo (
    .clk(ref_clk),
    .rst(rst),
    .inData({txInLast, txInUser[USER_UNDERRUN], cmdIn, txInData}), // [R19]
    .inValid(txInValid),
    .inReady(txInReady),
    .outData(fWord),
    .outValid(fValid),
    .outReady(fPop)
  );

  // transmit byte selection and insertion decode
  always_comb
  begin
    txAdv = !txOutValid || txOutReady;
    fPop = txAdv && (txStateQ == TX_DATA);
    popNow = fPop && fValid;
    cmdNow = txSofQ ? fWord[BYTE_W +: CMD_W] : txCmdQ; // [R17]
    stampTx = stampOf(useCorrFormat, timeNow, corrNow, txLatQ, 1'b0); // [R1] [R3] [R4]
    tsNow = txSofQ ? stampTx : txTimeQ;
    op = cmdNow[CMD_OP_LO +: 2];
    oneStep = (op == OP_ONE_STEP); // [R21]
    tsOff = cmdNow[CMD_TS_OFF_LO +: OFF_W];
    chkOff = useCorrFormat ? tsOff - CORR_CHK_GAP : cmdNow[CMD_CHK_OFF_LO +: OFF_W];
    rel = txPosQ - tsOff;
    tsIdx = rel + (useCorrFormat ? CORR_SKIP_BYTES : 16'h0000);
    inTs = oneStep && (txPosQ >= tsOff) &&
      (rel < (useCorrFormat ? CORR_STAMP_BYTES : DAY_STAMP_BYTES)); // [R23]
    inChk = oneStep && cmdNow[CMD_CHK_UPD] &&
      ((txPosQ == chkOff) || (txPosQ == chkOff + 16'h0001));
    if (inTs)
      outByte = pickByte(tsNow, tsIdx[3:0]); // [R2]
    else if (inChk)
      outByte = 8'h00; // [R2] zero checksum marks it unused
    else
      outByte = fWord[BYTE_W-1:0];
  end

  // sequencer: frame bytes, then four fcs bytes over modified data
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      txStateQ <= TX_DATA;
      fcsCntQ <= '0;
    end
    else
    begin
      unique case (txStateQ)
        TX_DATA:
        begin
          if (popNow && fWord[TXF_LAST])
          begin
            txStateQ <= TX_FCS;
            fcsCntQ <= '0;
          end
        end
        TX_FCS:
        begin
          if (txAdv)
          begin
            fcsCntQ <= fcsCntQ + 1'b1;
            if (fcsCntQ == FCS_LAST)
              txStateQ <= TX_DATA;
          end
        end
      endcase
    end
  end

  // frame tracking, command and time latch, crc
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      txSofQ <= 1'b1;
      txPosQ <= '0;
      txCmdQ <= '0;
      txTimeQ <= '0;
      crcQ <= CRC_INIT;
    end
    else if (popNow)
    begin
      txSofQ <= fWord[TXF_LAST];
      // back to 0 at frame end so the next first byte is position 0
      txPosQ <= fWord[TXF_LAST] ? '0 : txPosQ + 16'h0001;
      crcQ <= crcByte(txSofQ ? CRC_INIT : crcQ, outByte); // [R2]
      if (txSofQ)
      begin
        txCmdQ <= cmdNow;
        txTimeQ <= stampTx; // [R1]
      end
    end
  end

  // transmit output register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      txOutValid <= 1'b0;
      txOutData <= '0;
      txOutLast <= 1'b0;
      txOutUnderrun <= 1'b0;
    end
    else if (txAdv)
    begin
      if (txStateQ == TX_DATA)
      begin
        txOutValid <= fValid;
        txOutData <= outByte;
        txOutLast <= 1'b0;
        txOutUnderrun <= fValid && fWord[TXF_UNDERRUN]; // [R18]
      end
      else
      begin
        txOutValid <= 1'b1;
        txOutData <= ~crcQ[8*fcsCntQ +: BYTE_W]; // [R2]
        txOutLast <= (fcsCntQ == FCS_LAST);
        txOutUnderrun <= 1'b0;
      end
    end
  end

  // transmit stamp return with tag, one-step and two-step only
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      txStampValid <= 1'b0;
      txStampTime <= '0;
      txStampTag <= '0;
    end
    else
    begin
      txStampValid <= popNow && txSofQ && (op == OP_ONE_STEP || op == OP_TWO_STEP); // [R21]
      if (popNow && txSofQ)
      begin
        txStampTime <= stampTx;
        txStampTag <= cmdNow[CMD_TAG_LO +: TAG_W]; // [R22]
      end
    end
  end

  // ---------------- receive (ref_clk is the mac receive clock) ----------------
  logic [TIME_W-1:0] rxCapQ; // adjusted capture at phy delimiter
  logic rxSofQ;
  logic rxInlQ; // current frame carries an in-line stamp
  logic [3:0] inlCntQ;
  logic rxFirst;
  logic modeNow;
  logic [BYTE_W-1:0] dlyData [INL_BYTES];
  logic [INL_BYTES-1:0] dlyValid;
  logic [INL_BYTES-1:0] dlyLast;
  logic [INL_BYTES-1:0] dlyFirst;

  assign rxFirst = rxInValid && rxSofQ;
  assign modeNow = rxFirst ? inlineRxEnable : rxInlQ;

  // capture at phy delimiter, latency removed
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rxCapQ <= '0;
    else if (phySfd)
      rxCapQ <= stampOf(useCorrFormat, timeNow, corrNow, rxLatQ, 1'b1); // [R8] [R9] [R4]
  end

  // frame tracking and in-line byte counter
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rxSofQ <= 1'b1;
      rxInlQ <= 1'b0;
      inlCntQ <= '0;
    end
    else
    begin
      if (rxInValid)
        rxSofQ <= rxInLast;
      if (rxFirst)
        rxInlQ <= inlineRxEnable;
      if (rxFirst && inlineRxEnable)
        inlCntQ <= INL_COUNT - 4'h1; // [R14]
      else if (inlCntQ != '0)
        inlCntQ <= inlCntQ - 4'h1;
    end
  end

  // delay line holding frame bytes while the stamp is sent
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dlyValid <= '0;
      dlyLast <= '0;
      dlyFirst <= '0;
    end
    else
    begin
      dlyValid <= {dlyValid[INL_BYTES-2:0], rxInValid};
      dlyLast <= {dlyLast[INL_BYTES-2:0], rxInLast};
      dlyFirst <= {dlyFirst[INL_BYTES-2:0], rxFirst};
    end
    dlyData[0] <= rxInData;
    for (int i = 1; i < INL_BYTES; i++)
      dlyData[i] <= dlyData[i-1];
  end

  // receive output register: stamp, delayed frame or direct frame
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rxOutValid <= 1'b0;
      rxOutData <= '0;
      rxOutLast <= 1'b0;
    end
    else if (rxFirst && inlineRxEnable)
    begin
      rxOutValid <= 1'b1; // [R14] [R6] first byte of low seconds
      rxOutData <= pickByte({16'h0000, rxCapQ[CMD_W-1:0]}, 4'h2);
      rxOutLast <= 1'b0;
    end
    else if (inlCntQ != '0)
    begin
      rxOutValid <= 1'b1;
      rxOutData <= pickByte({16'h0000, rxCapQ[CMD_W-1:0]}, 4'ha - inlCntQ); // [R6] [R7]
      rxOutLast <= 1'b0;
    end
    else if (modeNow)
    begin
      rxOutValid <= dlyValid[INL_BYTES-1];
      rxOutData <= dlyData[INL_BYTES-1];
      rxOutLast <= dlyLast[INL_BYTES-1];
    end
    else
    begin
      rxOutValid <= rxInValid; // [R15]
      rxOutData <= rxInData;
      rxOutLast <= rxInLast;
    end
  end

  // dedicated stamp stream, aligned with first frame byte out
  always_ff @(posedge ref_clk) // [R12]
  begin
    if (rst)
    begin
      rxStampStreamValid <= 1'b0;
      rxStampStreamData <= '0;
    end
    else
    begin
      rxStampStreamValid <= (rxFirst && !inlineRxEnable) ||
        (rxInlQ && dlyFirst[INL_BYTES-1]); // [R11] [R24]
      if ((rxFirst && !inlineRxEnable) || (rxInlQ && dlyFirst[INL_BYTES-1]))
        rxStampStreamData <= {48'h0, rxCapQ}; // [R5] [R13]
    end
  end

  // ---------------- checks ----------------
  property p_txCapture;
    @(posedge ref_clk) disable iff (rst)
    popNow && txSofQ && (op == OP_TWO_STEP) |=> txStampValid && (txStampTime == $past(stampTx));
  endproperty
  a_txCapture: assert property (p_txCapture) else $error("tx stamp not captured at start"); // [R1]

  property p_txLatAdd;
    @(posedge ref_clk) disable iff (rst)
    popNow && txSofQ && !useCorrFormat && (timeNow[NS_W-1:0] < NS_PER_SEC - txLatQ)
      |=> txStampTime == $past(timeNow) + {48'h0, $past(txLatQ)};
  endproperty
  a_txLatAdd: assert property (p_txLatAdd) else $error("tx latency not added"); // [R3]

  property p_txCorrLat;
    @(posedge ref_clk) disable iff (rst)
    popNow && txSofQ && useCorrFormat
      |=> txStampTime[CMD_W-1:0] == $past(corrNow) + {16'h0, $past(txLatQ), 16'h0};
  endproperty
  a_txCorrLat: assert property (p_txCorrLat) else $error("correction latency wrong"); // [R4]

  property p_txTag;
    @(posedge ref_clk) disable iff (rst)
    popNow && txSofQ |=> txStampTag == $past(fWord[BYTE_W + CMD_TAG_LO +: TAG_W]);
  endproperty
  a_txTag: assert property (p_txTag) else $error("tag not returned"); // [R22]

  property p_tsInsert;
    @(posedge ref_clk) disable iff (rst)
    popNow && oneStep && !useCorrFormat && (txPosQ == tsOff)
      |=> txOutData == $past(tsNow[TIME_W-1 -: BYTE_W]);
  endproperty
  a_tsInsert: assert property (p_tsInsert) else $error("stamp not at offset"); // [R23]

  property p_underrun;
    @(posedge ref_clk) disable iff (rst)
    popNow |=> txOutUnderrun == $past(fWord[TXF_UNDERRUN]);
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not carried"); // [R18]

  property p_rxCapture;
    @(posedge ref_clk) disable iff (rst)
    phySfd && useCorrFormat ##1 !phySfd
      |-> rxCapQ[CMD_W-1:0] == $past(corrNow) - {16'h0, $past(rxLatQ), 16'h0};
  endproperty
  a_rxCapture: assert property (p_rxCapture) else $error("rx capture wrong"); // [R9]

  property p_rxDirect;
    @(posedge ref_clk) disable iff (rst)
    rxFirst && !inlineRxEnable |=> rxStampStreamValid && rxOutValid && (rxOutData == $past(rxInData));
  endproperty
  a_rxDirect: assert property (p_rxDirect) else $error("stamp not with first word"); // [R11]

  property p_rxInline;
    @(posedge ref_clk) disable iff (rst)
    rxFirst && inlineRxEnable
      |=> (rxOutData == rxCapQ[63:56]) && !rxStampStreamValid ##7 !rxStampStreamValid
      ##1 rxStampStreamValid;
  endproperty
  a_rxInline: assert property (p_rxInline) else $error("in-line stamp misplaced"); // [R14]

  property p_rxOnce;
    @(posedge ref_clk) disable iff (rst)
    rxStampStreamValid |=> !rxStampStreamValid;
  endproperty
  a_rxOnce: assert property (p_rxOnce) else $error("stamp valid longer than one cycle"); // [R24]

  property p_rxLayout;
    @(posedge ref_clk) disable iff (rst)
    rxStampStreamValid |-> rxStampStreamData[STAMP_W-1:TIME_W] == '0;
  endproperty
  a_rxLayout: assert property (p_rxLayout) else $error("reserved stamp bits set"); // [R13]

  c_oneStep: cover property (@(posedge ref_clk) popNow && txSofQ && oneStep);
  c_fcsEnd: cover property (@(posedge ref_clk) txStateQ == TX_FCS && fcsCntQ == FCS_LAST);
  c_rxInline: cover property (@(posedge ref_clk) rxFirst && inlineRxEnable);
  c_fifoFull: cover property (@(posedge ref_clk) txInValid && !txInReady);
endmodule
`default_nettype wire

// ==== tb/pts_client_model.sv ====
// client-side model: sends transmit frames and sinks the mac-side byte stream
`timescale 1ns/1ps
`default_nettype none
module pts_client_model (
  input wire logic ref_clk,
  output logic [pts_pkg::BYTE_W-1:0] txInData,
  output logic txInValid,
  output logic txInLast,
  output logic [pts_pkg::USER_W-1:0] txInUser,
  input wire logic txInReady,
  input wire logic [pts_pkg::BYTE_W-1:0] txOutData,
  input wire logic txOutValid,
  input wire logic txOutLast,
  output logic txOutReady,
  input wire logic stall
);
  import pts_pkg::*;
  logic [BYTE_W-1:0] seen[$]; // bytes taken from the mac side
  int lastAt = 0; // one more than the count of bytes when the last flag came
  int hung = 0; // transfers not accepted within 100 cycles
  initial
  begin
    txInData = 8'h00;
    txInValid = 1'b0;
    txInLast = 1'b0;
    txInUser = '0;
    txOutReady = 1'b1;
  end
  // sink toggles ready every cycle while stalling
  always @(posedge ref_clk)
  begin
    txOutReady <= #1 !stall || !txOutReady;
    if (txOutValid === 1'b1 && txOutReady)
    begin
      seen.push_back(txOutData);
      if (txOutLast === 1'b1)
        lastAt = seen.size() + 1;
    end
  end
  // one frame of n bytes; command rides with the first byte only
  task automatic send(input logic [CMD_W-1:0] cmd, input int n);
    int k;
    for (int i = 0; i < n; i++)
    begin
      txInData = 8'(8'h20 + i);
      txInValid = 1'b1;
      txInLast = (i == n - 1);
      // reserved bits set, command inverted after the first byte, underrun on the last
      txInUser = {(i == 0) ? cmd : ~cmd, {63{1'b1}}, (i == n - 1)};
      k = 0;
      do
      begin
        @(posedge ref_clk);
        k++;
      end while (txInReady !== 1'b1 && k < 100);
      if (k >= 100)
        hung++;
      #1;
    end
    txInValid = 1'b0;
    txInLast = 1'b0;
    txInUser = '1;
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the timestamp path
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pts_pkg::*;
  logic ref_clk, rst, useCorrFormat, inlineCmdEnable, inlineRxEnable, stall;
  logic txLatencyLoad, rxLatencyLoad, phySfd, rxInValid, rxInLast;
  logic [TIME_W-1:0] timeNow, txStampTime, txTime, expV;
  logic [CMD_W-1:0] corrNow;
  logic [31:0] txLatencyNs, rxLatencyNs;
  logic [BYTE_W-1:0] txInData, rxInData, txOutData, rxOutData;
  logic [USER_W-1:0] txInUser;
  logic txInValid, txInLast, txInReady, txOutValid, txOutLast, txOutUnderrun, txOutReady;
  logic [TAG_W-1:0] txStampTag, txTag;
  logic txStampValid, rxOutValid, rxOutLast, rxStampStreamValid;
  logic [STAMP_W-1:0] rxStampStreamData, rxStamp;
  logic [BYTE_W-1:0] rxSeen[$]; // receive bytes seen by the client
  int n_errors = 0;
  int n_compared = 0;
  int nRx, nTx, rxAt, nUnd;
  logic [31:0] crcV;
  pts_timestamp_path pts_timestamp_path_i (.ref_clk, .rst, .timeNow, .corrNow, .useCorrFormat,
    .inlineCmdEnable, .inlineRxEnable, .txLatencyNs, .txLatencyLoad, .rxLatencyNs,
    .rxLatencyLoad, .txInData, .txInValid, .txInLast, .txInUser, .txInReady, .txOutData,
    .txOutValid, .txOutLast, .txOutUnderrun, .txOutReady, .txStampTime, .txStampTag,
    .txStampValid, .phySfd, .rxInData, .rxInValid, .rxInLast, .rxOutData, .rxOutValid,
    .rxOutLast, .rxStampStreamData, .rxStampStreamValid);
  pts_client_model pts_client_model_i (.ref_clk, .txInData, .txInValid, .txInLast, .txInUser,
    .txInReady, .txOutData, .txOutValid, .txOutLast, .txOutReady, .stall);
  // 125 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // collect receive bytes, receive stamps and transmit stamps
  always @(posedge ref_clk)
  begin
    if (rxStampStreamValid === 1'b1)
    begin
      nRx++;
      rxAt = (rxOutValid === 1'b1) ? rxSeen.size() : -1;
      rxStamp = rxStampStreamData;
    end
    if (rxOutValid === 1'b1)
      rxSeen.push_back(rxOutData);
    if (txStampValid === 1'b1)
    begin
      nTx++;
      txTime = txStampTime;
      txTag = txStampTag;
    end
    if (txOutUnderrun === 1'b1 && txOutValid === 1'b1 && txOutReady === 1'b1)
      nUnd++;
  end
  // reflected crc32 step, for the fcs residue check
  function automatic logic [31:0] crcStep(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h0, b};
    for (int j = 0; j < 8; j++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // delimiter pulse, then n bytes, then an idle gap long enough to drain
  task automatic rx_frame(input int n);
    rxSeen.delete();
    nRx = 0;
    rxAt = -2;
    phySfd = 1'b1;
    tick();
    phySfd = 1'b0;
    tick();
    for (int i = 0; i < n; i++)
    begin
      rxInData = 8'(8'h55 + i);
      rxInValid = 1'b1;
      rxInLast = (i == n - 1);
      tick();
    end
    rxInValid = 1'b0;
    rxInLast = 1'b0;
    repeat (14) tick();
  endtask
  // one 16-byte frame through the client, waiting for the last byte out
  task automatic tx_frame(input logic [CMD_W-1:0] cmd);
    int k;
    nTx = 0;
    nUnd = 0;
    pts_client_model_i.seen.delete();
    pts_client_model_i.lastAt = 0;
    pts_client_model_i.send(cmd, 16);
    for (k = 0; k < 200 && pts_client_model_i.lastAt == 0; k++)
      tick();
    if (k == 200)
    begin
      n_errors++;
      give_verdict();
    end
    tick();
    crcV = CRC_INIT;
    for (k = 0; k < 20; k++)
      crcV = crcStep(crcV, pts_client_model_i.seen[k]);
    check("tx fcs residue", 32'hdebb20e3, crcV);
    check("tx underrun beats", 1, nUnd);
  endtask
  initial
  begin
    rst = 1'b1;
    stall = 1'b0;
    useCorrFormat = 1'b0;
    inlineCmdEnable = 1'b0;
    inlineRxEnable = 1'b0;
    txLatencyLoad = 1'b0;
    rxLatencyLoad = 1'b0;
    txLatencyNs = 32'h00000000;
    rxLatencyNs = 32'h00000000;
    phySfd = 1'b0;
    rxInData = 8'h00;
    rxInValid = 1'b0;
    rxInLast = 1'b0;
    timeNow = {48'h000000001234, 32'h00001000};
    corrNow = 64'h0000000001000000; // plain numeric correction value
    repeat (5) tick();
    rst = 1'b0;
    tick();
    check("tx ready after reset", 1, txInReady);
    check("rx stamp valid after reset", 0, rxStampStreamValid);
    $display("test reset done");
    rx_frame(4);
    check("rx stamp", {48'h0, timeNow - 80'h30}, rxStamp);
    check("rx stamp count", 1, nRx);
    check("rx stamp position", 0, rxAt);
    check("rx byte count", 4, rxSeen.size());
    check("rx first byte", 8'h55, rxSeen[0]);
    $display("test rx out of band done");
    inlineRxEnable = 1'b1;
    rx_frame(4);
    expV = timeNow - 80'h30;
    for (int i = 0; i < 8; i++)
      check("inline stamp byte", expV[63 - 8*i -: 8], rxSeen[i]);
    check("inline first frame byte", 8'h55, rxSeen[8]);
    check("inline stamp position", 8, rxAt);
    check("inline byte count", 12, rxSeen.size());
    $display("test rx inline done");
    inlineRxEnable = 1'b0;
    rxLatencyNs = 32'h00000100;
    rxLatencyLoad = 1'b1;
    tick();
    rxLatencyLoad = 1'b0;
    rx_frame(2);
    check("rx stamp new latency", {48'h0, timeNow - 80'h100}, rxStamp);
    $display("test rx latency done");
    stall = 1'b1;
    expV = timeNow + 80'h40;
    for (int op = 0; op < 4; op++)
    begin
      tx_frame({16'h0000, 16'h0002, 16'(16'h1110 + op), 14'h0, 2'(op)});
      check("tx stamp count", (op == 1 || op == 2), nTx);
      if (op == 1 || op == 2)
      begin
        check("tx stamp time", expV, txTime);
        check("tx stamp tag", 16'(16'h1110 + op), txTag);
      end
      check("tx bytes out", 20, pts_client_model_i.lastAt - 1);
      for (int i = 0; i < 16; i++)
        check("tx byte", (op == 1 && i > 1 && i < 12) ? expV[79 - 8*(i-2) -: 8]
          : 8'(8'h20 + i), pts_client_model_i.seen[i]);
    end
    $display("test tx commands done");
    inlineCmdEnable = 1'b1;
    tx_frame(64'h000000002222_0002);
    check("tx stamp count inline command", 0, nTx);
    inlineCmdEnable = 1'b0;
    useCorrFormat = 1'b1;
    txLatencyNs = 32'h00000010;
    txLatencyLoad = 1'b1;
    tick();
    txLatencyLoad = 1'b0;
    tx_frame(64'h000000003333_0002);
    check("tx correction stamp", {16'h0, corrNow + 64'h100000}, txTime);
    tx_frame(64'h0000000a44440101);
    expV = {16'h0, corrNow + 64'h100000};
    for (int i = 0; i < 16; i++)
      check("corr byte", (i < 2) ? 8'h00 : (i > 9) ? expV[63 - 8*(i-10) -: 8] : 8'(8'h20 + i),
        pts_client_model_i.seen[i]);
    rx_frame(2);
    check("rx correction stamp", {64'h0, corrNow - 64'h1000000}, rxStamp);
    check("tx client hangs", 0, pts_client_model_i.hung);
    $display("test tx correction done");
    give_verdict();
  end
endmodule
`default_nettype wire
